// ==== verilog/tplink_regs.vh ====
// timing constants for the twisted-pair link, pulse and led block
`ifndef TPLINK_REGS_VH
`define TPLINK_REGS_VH
`define TPL_CLK_MHZ        250
`define TPL_LTP_IVL_US     16000
`define TPL_LTP_W_NS       100
`define TPL_LTP_HALF_NS    50
`define TPL_RX_MIN_US      4000
`define TPL_RX_MAX_US      65000
`define TPL_HALF_BIT_NS    50
`define TPL_EOP0_NS        250
`define TPL_EOP1_NS        300
`define TPL_PREDIST_NS     50
`define TPL_LED_MS         128
`define TPL_LOOP_SETUP_NS  100
`endif

// ==== verilog/tplink_core.v ====
// twisted-pair link pulse, manchester shaping and led stretch logic
//
// Notes on behaviour
// - idle link pulse every 16 ms
// - pulse 100 ns primary, 50 ns delayed
// - valid rx pulse spacing 4 to 65 ms
// - manchester half-bit cells of 50 ns
// - end-of-packet hold 250 or 300 ns
// - during frames, delayed outputs repeat primary after 50 ns
// - activity leds stretched for 128 ms
`timescale 1ns/1ps
`include "tplink_regs.vh"
module tplink_core #(
  parameter LTP_IVL   = `TPL_LTP_IVL_US * `TPL_CLK_MHZ,  // link pulse period
  parameter RX_MIN    = `TPL_RX_MIN_US * `TPL_CLK_MHZ,   // least rx spacing
  parameter RX_MAX    = `TPL_RX_MAX_US * `TPL_CLK_MHZ,   // longest rx spacing
  parameter LED_HOLD  = `TPL_LED_MS * 1000 * `TPL_CLK_MHZ // led stretch
) (
  input  wire mclk_i,               // device clock 250 MHz
  input  wire reset_i,              // async reset, active high
  input  wire clk_en_i,             // freezes all state when low
  input  wire tx_en_i,              // mac frame transmit active
  input  wire tx_data_i,            // nrz bit, taken at bit start
  output wire tx_bit_req_o,         // pulse: next bit taken
  input  wire rx_pulse_i,           // link pulse seen on line (async)
  input  wire rx_packet_i,          // packet carrier on line (async)
  input  wire col_i,                // collision seen (async)
  input  wire loopback_control_bit, // external loopback select
  output reg  tp_pos_primary_out,   // positive primary drive
  output reg  tp_neg_primary_out,   // negative primary drive
  output reg  tp_pos_delayed_out,   // positive predistort drive
  output reg  tp_neg_delayed_out,   // negative predistort drive
  output reg  link_ok_o,            // link pass indication
  output reg  loopback_o,           // loopback latched for frame
  output reg  led_tx_o,             // transmit led
  output reg  led_rx_o,             // receive led
  output reg  led_col_o             // collision led
);
  // cycle counts derived from times
  localparam HALF_CYC = (`TPL_HALF_BIT_NS * `TPL_CLK_MHZ + 999) / 1000;
  localparam LTPW_CYC = (`TPL_LTP_W_NS * `TPL_CLK_MHZ + 999) / 1000;
  localparam DLY_CYC  = (`TPL_PREDIST_NS * `TPL_CLK_MHZ + 999) / 1000;
  localparam EOP0_CYC = (`TPL_EOP0_NS * `TPL_CLK_MHZ + 999) / 1000;
  localparam EOP1_CYC = (`TPL_EOP1_NS * `TPL_CLK_MHZ + 999) / 1000;
  localparam LTPH_CYC = (`TPL_LTP_HALF_NS * `TPL_CLK_MHZ + 999) / 1000;
  // one-hot transmit states
  localparam S_IDLE = 4'b0001;
  localparam S_DATA = 4'b0010;
  localparam S_EOP  = 4'b0100;
  localparam S_LTP  = 4'b1000;

  reg  [3:0]  state;        // transmit state
  reg  [31:0] tcnt;         // cell or hold counter
  reg  [31:0] ltp_cnt;      // idle interval counter
  reg         half;         // second half of bit cell
  reg         bit_q;        // current data bit
  reg         pos_a;        // primary positive, undelayed
  reg         neg_a;        // primary negative, undelayed
  reg  [15:0] dpos;         // delay line positive
  reg  [15:0] dneg;         // delay line negative
  reg  [15:0] dltp;         // link pulse marks, aligned with dpos
  reg  [2:0]  rxp_s;        // pulse synchroniser and edge
  reg  [1:0]  rxk_s;        // packet synchroniser
  reg  [1:0]  col_s;        // collision synchroniser
  reg  [31:0] rx_cnt;       // time since last rx pulse
  reg  [31:0] led_tx_cnt;   // tx led stretch count
  reg  [31:0] led_rx_cnt;   // rx led stretch count
  reg  [31:0] led_col_cnt;  // col led stretch count

  assign tx_bit_req_o = clk_en_i & (state == S_DATA) & half &
                        (tcnt == HALF_CYC - 1) & tx_en_i;

  // transmit shaping machine
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state   <= S_IDLE;
      tcnt    <= 32'h0000_0000;
      ltp_cnt <= 32'h0000_0000;
      half    <= 1'b0;
      bit_q   <= 1'b0;
      pos_a   <= 1'b0;
      neg_a   <= 1'b0;
      loopback_o <= 1'b0;
    end else if (clk_en_i) begin
      case (state)
        S_IDLE: begin
          pos_a <= 1'b0;
          neg_a <= 1'b0;
          if (tx_en_i) begin             // frame start, first cell
            state <= S_DATA;
            bit_q <= tx_data_i;
            half  <= 1'b0;
            tcnt  <= 32'h0000_0000;
            loopback_o <= loopback_control_bit;
            pos_a <= ~tx_data_i;
            neg_a <= tx_data_i;
          end else if (ltp_cnt >= LTP_IVL - 1) begin
            state   <= S_LTP;
            ltp_cnt <= 32'h0000_0000;
            tcnt    <= 32'h0000_0000;
            pos_a   <= 1'b1;
          end else begin
            ltp_cnt <= ltp_cnt + 32'h0000_0001;
          end
        end
        S_DATA: begin
          if (tcnt == HALF_CYC - 1) begin
            tcnt <= 32'h0000_0000;
            if (!half) begin
              half  <= 1'b1;
              pos_a <= bit_q;
              neg_a <= ~bit_q;
            end else if (tx_en_i) begin
              half  <= 1'b0;
              bit_q <= tx_data_i;
              pos_a <= ~tx_data_i;
              neg_a <= tx_data_i;
            end else begin
              state <= S_EOP;             // hold last level
            end
          end else begin
            tcnt <= tcnt + 32'h0000_0001;
          end
        end
        S_EOP: begin
          if (tcnt >= (bit_q ? EOP1_CYC : EOP0_CYC) - 1) begin
            state   <= S_IDLE;
            pos_a   <= 1'b0;
            neg_a   <= 1'b0;
            tcnt    <= 32'h0000_0000;
            ltp_cnt <= 32'h0000_0000;
          end else begin
            tcnt <= tcnt + 32'h0000_0001;
          end
        end
        S_LTP: begin
          // interval keeps running through the pulse
          ltp_cnt <= ltp_cnt + 32'h0000_0001;
          if (tcnt >= LTPW_CYC - 1) begin
            state <= S_IDLE;
            pos_a <= 1'b0;
            tcnt  <= 32'h0000_0000;
          end else begin
            tcnt <= tcnt + 32'h0000_0001;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // primary registers and predistortion delay lines
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      dpos <= 16'h0000;
      dneg <= 16'h0000;
      dltp <= 16'h0000;
      tp_pos_primary_out <= 1'b0;
      tp_neg_primary_out <= 1'b0;
      tp_pos_delayed_out <= 1'b0;
      tp_neg_delayed_out <= 1'b0;
    end else if (clk_en_i) begin
      dpos <= {dpos[14:0], pos_a};
      dneg <= {dneg[14:0], neg_a};
      dltp <= {dltp[14:0], (state == S_LTP)};
      tp_pos_primary_out <= pos_a;
      tp_neg_primary_out <= neg_a;
      if (state == S_LTP) begin
        // link pulse: delayed pair fires for the last half only
        tp_pos_delayed_out <= (tcnt >= LTPH_CYC);
        tp_neg_delayed_out <= (tcnt >= LTPH_CYC);
      end else if (dltp[DLY_CYC-1]) begin
        // link pulse tail in the delay line is not repeated
        tp_pos_delayed_out <= 1'b0;
        tp_neg_delayed_out <= 1'b0;
      end else begin
        tp_pos_delayed_out <= dpos[DLY_CYC-1];
        tp_neg_delayed_out <= dneg[DLY_CYC-1];
      end
    end
  end

  // receive link integrity
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rxp_s     <= 3'b000;
      rxk_s     <= 2'b00;
      col_s     <= 2'b00;
      rx_cnt    <= RX_MAX - 1;          // no earlier pulse to time from
      link_ok_o <= 1'b0;
    end else if (clk_en_i) begin
      rxp_s <= {rxp_s[1:0], rx_pulse_i};
      rxk_s <= {rxk_s[0], rx_packet_i};
      col_s <= {col_s[0], col_i};
      if (rxk_s[1]) begin
        rx_cnt    <= 32'h0000_0000;     // packet keeps link up
        link_ok_o <= 1'b1;
      end else if (rxp_s[1] & ~rxp_s[2]) begin
        rx_cnt <= 32'h0000_0000;
        if (rx_cnt >= RX_MIN - 1 && rx_cnt < RX_MAX - 1)
          link_ok_o <= 1'b1;
      end else if (rx_cnt >= RX_MAX - 1) begin
        link_ok_o <= 1'b0;
      end else begin
        rx_cnt <= rx_cnt + 32'h0000_0001;
      end
    end
  end

  // led stretchers
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      led_tx_cnt  <= 32'h0000_0000;
      led_rx_cnt  <= 32'h0000_0000;
      led_col_cnt <= 32'h0000_0000;
      led_tx_o    <= 1'b0;
      led_rx_o    <= 1'b0;
      led_col_o   <= 1'b0;
    end else if (clk_en_i) begin
      led_tx_cnt  <= (state == S_DATA) ? LED_HOLD :
                     (led_tx_cnt != 0) ? led_tx_cnt - 1 : 0;
      led_rx_cnt  <= rxk_s[1] ? LED_HOLD :
                     (led_rx_cnt != 0) ? led_rx_cnt - 1 : 0;
      led_col_cnt <= col_s[1] ? LED_HOLD :
                     (led_col_cnt != 0) ? led_col_cnt - 1 : 0;
      led_tx_o    <= (led_tx_cnt != 0);
      led_rx_o    <= (led_rx_cnt != 0);
      led_col_o   <= (led_col_cnt != 0);
    end
  end
endmodule // tplink_core

// ==== dv/tpl_core_chk_assertions.sv ====
// concurrent checks of shaping, link and led timing at the core ports
`timescale 1ns/1ps
module tpl_core_chk (
  input wire mclk_i,             // device clock
  input wire reset_i,            // async reset
  input wire clk_en_i,           // clock enable
  input wire tx_en_i,            // frame active
  input wire tx_bit_req_o,       // bit taken
  input wire rx_packet_i,        // packet carrier
  input wire col_i,              // collision
  input wire tp_pos_primary_out, // positive drive
  input wire tp_pos_delayed_out, // positive predistort
  input wire tp_neg_primary_out, // negative drive
  input wire tp_neg_delayed_out, // negative predistort
  input wire link_ok_o,          // link pass
  input wire led_rx_o,           // receive led
  input wire led_col_o           // collision led
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  dly_pos_a: assert property ($past(tx_bit_req_o, 13) |->
    tp_pos_delayed_out == $past(tp_pos_primary_out, 13)) else $error("pos lag");
  dly_neg_a: assert property ($past(tx_bit_req_o, 13) |->
    tp_neg_delayed_out == $past(tp_neg_primary_out, 13)) else $error("neg lag");
  half_cell_a: assert property (tx_bit_req_o |->
    tp_pos_primary_out == $past(tp_pos_primary_out, 11) &&
    tp_pos_primary_out != $past(tp_pos_primary_out, 12)) else $error("half");
  req_gap_a: assert property (tx_bit_req_o |=> !tx_bit_req_o [*8])
    else $error("bit cell short");
  pair_diff_a: assert property (tx_bit_req_o |->
    tp_pos_primary_out != tp_neg_primary_out) else $error("pair not opposite");
  pulse_w_a: assert property (!tx_en_i && $rose(tp_pos_primary_out)
    |-> tp_pos_primary_out [*8]) else $error("link pulse short");
  col_led_a: assert property (clk_en_i && $rose(col_i) |->
    ##[1:5] led_col_o)
    else $error("collision led late");
  led_hold_a: assert property ($rose(led_rx_o) |-> led_rx_o [*8])
    else $error("rx led short");
  link_up_a: assert property ($rose(rx_packet_i) |-> ##[1:5] link_ok_o)
    else $error("link not up on packet");
endmodule // tpl_core_chk
bind tplink_core tpl_core_chk tpl_core_chk_inst (.*);

// ==== dv/tpl_cable.sv ====
// cable side model sending link pulses at a set spacing
`timescale 1ns/1ps
module tpl_cable (
  input  wire        mclk_i,    // device clock
  input  wire        run_i,     // pulse train on
  input  wire [15:0] gap_i,     // spacing in cycles
  output reg         rx_pulse_o // received pulse
);
  reg [15:0] cnt; // spacing counter
  initial begin
    cnt = 16'h0000;
    rx_pulse_o = 1'b0;
  end
  // three cycle pulse at each spacing wrap, quiet when stopped
  always @(posedge mclk_i) begin
    cnt <= (!run_i || cnt >= gap_i - 1) ? 16'h0000 : cnt + 1;
    rx_pulse_o <= run_i && cnt < 3;
  end
endmodule // tpl_cable

// ==== dv/tb.sv ====
// self-checking bench for the twisted-pair timing core
`timescale 1ns/1ps
module tb;
  reg mclk_i = 0, reset_i = 1, tx_en_i = 0, tx_data_i = 0;
  reg rx_packet_i = 0, col_i = 0, loopback_control_bit = 0, run = 0;
  reg clk_en = 1;
  reg [15:0] gap = 16'h0032; // early spacing first
  wire tx_bit_req_o, rx_pulse_i, tp_pos_primary_out, tp_neg_primary_out;
  wire tp_pos_delayed_out, tp_neg_delayed_out, link_ok_o, loopback_o;
  wire led_tx_o, led_rx_o, led_col_o;
  integer n_fail = 0, checked = 0, t, w;
  always #2 mclk_i = ~mclk_i;
  tplink_core #(.LTP_IVL(400), .RX_MIN(100), .RX_MAX(1600), .LED_HOLD(200))
    tplink_core_inst (.mclk_i, .reset_i, .clk_en_i(clk_en), .tx_en_i,
    .tx_data_i, .tx_bit_req_o, .rx_pulse_i, .rx_packet_i, .col_i,
    .loopback_control_bit, .tp_pos_primary_out, .tp_neg_primary_out,
    .tp_pos_delayed_out, .tp_neg_delayed_out, .link_ok_o, .loopback_o,
    .led_tx_o, .led_rx_o, .led_col_o);
  tpl_cable tpl_cable_inst (.mclk_i, .run_i(run), .gap_i(gap),
    .rx_pulse_o(rx_pulse_i));
  // range compare, unknown never matches
  task chk(input string nm, input [31:0] lo, hi, s);
    checked = checked + 1;
    if (^s === 1'bx || s < lo || s > hi) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo, hi, s);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge mclk_i);
  endtask
  // cycles until positive drive rises, then its high width
  task rise;
    t = 0;
    w = 0;
    while (tp_pos_primary_out !== 1'b1 && t < 5000) begin cyc(1); t++; end
    while (tp_pos_primary_out === 1'b1 && w < 500) begin cyc(1); w++; end
  endtask
  task wait_req;
    t = 0;
    cyc(1);
    while (tx_bit_req_o !== 1'b1 && t < 100) begin cyc(1); t++; end
  endtask
  task t_idle;
    rise;
    chk("pulse width", 24, 26, w);
    rise;
    chk("pulse interval", 375, 425, t + w);
    $display("test idle done");
  endtask
  task t_rx;
    run <= 1;
    cyc(700);
    chk("link early", 0, 0, link_ok_o);
    gap <= 16'h0190;
    cyc(1000);
    chk("link valid", 1, 1, link_ok_o);
    run <= 0;
    cyc(1800);
    chk("link lost", 0, 0, link_ok_o);
    rx_packet_i <= 1;
    cyc(6);
    chk("link packet", 1, 1, link_ok_o);
    chk("rx led", 1, 1, led_rx_o);
    rx_packet_i <= 0;
    $display("test rx done");
  endtask
  task t_tx;
    loopback_control_bit <= 1;
    cyc(30);
    tx_en_i <= 1;
    cyc(1);
    tx_data_i <= 1;
    wait_req;
    chk("loopback", 1, 1, loopback_o);
    chk("tx led", 1, 1, led_tx_o);
    wait_req;
    tx_en_i <= 0;
    cyc(3);
    rise;
    chk("end hold", 87, 89, w);
    cyc(25);
    loopback_control_bit <= 0;
    $display("test tx done");
  endtask
  task t_col;
    col_i <= 1;
    cyc(3);
    col_i <= 0;
    cyc(8);
    chk("col led on", 1, 1, led_col_o);
    cyc(250);
    chk("col led off", 0, 0, led_col_o);
    $display("test col done");
  endtask
  // frozen core ignores a collision
  task t_freeze;
    clk_en <= 0;
    col_i <= 1;
    cyc(10);
    col_i <= 0;
    cyc(2);
    clk_en <= 1;
    chk("col led frozen", 0, 0, led_col_o);
    cyc(8);
    chk("col led after", 0, 0, led_col_o);
    $display("test freeze done");
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(12);
    reset_i <= 0;
    t_idle;
    t_rx;
    t_tx;
    t_col;
    t_freeze;
    results;
  end
  // hang guard, about five times the expected run
  initial begin
    #100000;
    n_fail = n_fail + 1;
    results;
  end
endmodule // tb
